// >>> hw/sssp_pkg.sv
// Package of constants for the synchronous serial shift port
package sssp_pkg;
   // -----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [15:0] SSSP_IDX_CTRL = 16'hff70;
   localparam logic [15:0] SSSP_IDX_MODE = 16'hff71;
   localparam logic [15:0] SSSP_IDX_DLO = 16'hff72;
   localparam logic [15:0] SSSP_IDX_DHI = 16'hff73;
   localparam logic [15:0] SSSP_IDX_MASK = 16'hffe3;
   localparam logic [15:0] SSSP_IDX_FLAG = 16'hfff3;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int SSSP_CTRL_PFE = 0;
   localparam int SSSP_CTRL_TRG = 1;
   localparam int SSSP_MODE_CS_LO = 0;
   localparam int SSSP_MODE_CS_HI = 1;
   localparam int SSSP_MODE_PHASE = 2;
   localparam int SSSP_MODE_ORDER = 3;
   localparam int SSSP_FLAG_DONE = 0;
   localparam int SSSP_MASK_DONE = 0;

   // -----------------------------------------------------------------
   // Clock modes, reset values and counts
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SSSP_CS_SLAVE = 2'h0,
      SSSP_CS_TIMER = 2'h1,
      SSSP_CS_OSC_HALF = 2'h2,
      SSSP_CS_OSC = 2'h3
   } sssp_cs_e;

   localparam logic [1:0] SSSP_CS_RESET = 2'h0;
   localparam logic [3:0] SSSP_BITS = 4'h8;
   localparam logic [1:0] SSSP_RESP_OKAY = 2'h0;
   localparam logic [1:0] SSSP_RESP_SLVERR = 2'h2;
   localparam int SSSP_MAX_SCLK_KHZ = 1000;
   localparam int SSSP_MCLK_KHZ = 125000;
   localparam int SSSP_MIN_HALF_CYC = (SSSP_MCLK_KHZ + 2 * SSSP_MAX_SCLK_KHZ - 1)
                                      / (2 * SSSP_MAX_SCLK_KHZ);
endpackage

// >>> hw/sssp_top.sv
// Synchronous serial shift port with AXI4-Lite register access
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Two-bit mode field picks master source or slave
// - Timer source halves timer 1 underflow pulses
// - Reset leaves the port in slave mode
// - Master drives shift clock; slave uses pin clock
// - Master stops after 8 cycles, idles clock
// - Slave ignores clock edges after eight cycles
// - Shift clock never faster than 1 MHz; not limited here, rate follows the selected source or pin
// - Transfer completes after counting eight clock cycles
// - Nibbles loaded, trigger written, byte shifts out
// - Negative polarity: output on falling, phase picks shift
// - Positive polarity: output on rising, phase picks shift
// - Negative polarity: phase picks sampling edge
// - Positive polarity: phase picks sampling edge
// - Done flag always sets; interrupt needs mask
// - Received byte readable through data nibbles
// - Order bit picks LSB or MSB first
// - Slave mode drives ready on port pin 13
// - Negative ready idles high, low after trigger
// - Positive ready idles low, high after trigger
// - High nibble access returns ready to idle
// - Trigger read shows whether clock is running
// - Enable bit hands pins to serial function
module sssp_top #(
   parameter bit POS_POL = 1'b0,
   parameter int ADDR_W = 18
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic low_speed_osc_i,
   input wire logic timer1_underflow_i,
   input wire logic serial_in_pin_i,
   output logic serial_out_pin_o,
   output logic serial_out_oe_o,
   input wire logic sclk_pin_i,
   output logic sclk_pin_o,
   output logic sclk_pin_oe_o,
   output logic slave_ready_out_o,
   output logic slave_ready_oe_o,
   output logic transfer_irq_o
);
   import sssp_pkg::*;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] s;
      s = a >> 2;
      return s[15:0];
   endfunction

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [1:0] clock_mode_r;
   logic clock_phase_bit_r;
   logic bit_order_bit_r;
   logic port_function_enable_r;
   logic transfer_done_flag_r;
   logic transfer_irq_mask_r;
   logic running_r;
   logic [3:0] cycle_cnt_r;
   logic [7:0] transfer_data_byte_r;
   logic serial_out_pin_r;
   logic clk_int_r;
   logic clk_ext_prev_r;
   logic osc_prev_r;
   logic half_div_r;
   logic ready_r;
   logic aw_got_r;
   logic w_got_r;
   logic [15:0] aw_idx_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   // -----------------------------------------------------------------
   // Write path decode
   // -----------------------------------------------------------------
   logic wr_fire;
   logic rd_fire;
   logic [15:0] rd_idx;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_dlo;
   logic wr_dhi;
   logic wr_mask;
   logic wr_flag;
   logic wr_hit;
   logic trig_wr;

   assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid_o;
   assign rd_fire = s_axi_arvalid_i & s_axi_arready_o;
   assign rd_idx = reg_index(s_axi_araddr_i);
   assign wr_ctrl = wr_fire & wstrb_r[0] & (aw_idx_r == SSSP_IDX_CTRL);
   assign wr_mode = wr_fire & wstrb_r[0] & (aw_idx_r == SSSP_IDX_MODE);
   assign wr_dlo = wr_fire & wstrb_r[0] & (aw_idx_r == SSSP_IDX_DLO);
   assign wr_dhi = wr_fire & wstrb_r[0] & (aw_idx_r == SSSP_IDX_DHI);
   assign wr_mask = wr_fire & wstrb_r[0] & (aw_idx_r == SSSP_IDX_MASK);
   assign wr_flag = wr_fire & wstrb_r[0] & (aw_idx_r == SSSP_IDX_FLAG);
   assign wr_hit = (aw_idx_r == SSSP_IDX_CTRL) | (aw_idx_r == SSSP_IDX_MODE) |
                   (aw_idx_r == SSSP_IDX_DLO) | (aw_idx_r == SSSP_IDX_DHI) |
                   (aw_idx_r == SSSP_IDX_MASK) | (aw_idx_r == SSSP_IDX_FLAG);
   assign trig_wr = wr_ctrl & wdata_r[SSSP_CTRL_TRG];

   // -----------------------------------------------------------------
   // Shift clock edges
   // -----------------------------------------------------------------
   // Clock is normalised so that idle is 1 and the leading edge falls.
   logic master;
   logic tick;
   logic clk_ext;
   logic lead;
   logic trail;
   logic sample_edge;
   logic last_trail;

   assign master = (clock_mode_r != SSSP_CS_SLAVE);
   assign clk_ext = sclk_pin_i ^ POS_POL;

   always_comb begin
      case (sssp_cs_e'(clock_mode_r))
         SSSP_CS_OSC: tick = (low_speed_osc_i != osc_prev_r);
         SSSP_CS_OSC_HALF: tick = low_speed_osc_i & ~osc_prev_r;
         SSSP_CS_TIMER: tick = timer1_underflow_i;
         default: tick = 1'b0;
      endcase
   end

   always_comb begin
      if (master) begin
         lead = running_r & tick & clk_int_r;
         trail = running_r & tick & ~clk_int_r;
      end else begin
         // Edges outside a running transfer are masked
         lead = running_r & clk_ext_prev_r & ~clk_ext;
         trail = running_r & ~clk_ext_prev_r & clk_ext;
      end
   end

   // Phase 1 shifts and samples on the leading edge, phase 0 on trailing
   assign sample_edge = clock_phase_bit_r ? lead : trail;
   assign last_trail = trail & (cycle_cnt_r == SSSP_BITS - 4'h1);

   // -----------------------------------------------------------------
   // Configuration registers
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         clock_mode_r <= SSSP_CS_RESET;
         clock_phase_bit_r <= 1'b0;
         bit_order_bit_r <= 1'b0;
         port_function_enable_r <= 1'b0;
         transfer_irq_mask_r <= 1'b0;
      end else if (ce_i) begin
         if (wr_mode) begin
            clock_mode_r <= wdata_r[SSSP_MODE_CS_HI:SSSP_MODE_CS_LO];
            clock_phase_bit_r <= wdata_r[SSSP_MODE_PHASE];
            bit_order_bit_r <= wdata_r[SSSP_MODE_ORDER];
         end
         if (wr_ctrl) begin
            port_function_enable_r <= wdata_r[SSSP_CTRL_PFE];
         end
         if (wr_mask) begin
            transfer_irq_mask_r <= wdata_r[SSSP_MASK_DONE];
         end
      end
   end

   // -----------------------------------------------------------------
   // Transfer sequencing
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         running_r <= 1'b0;
         cycle_cnt_r <= 4'h0;
         clk_int_r <= 1'b1;
         clk_ext_prev_r <= 1'b1;
         osc_prev_r <= 1'b0;
      end else if (ce_i) begin
         osc_prev_r <= low_speed_osc_i;
         clk_ext_prev_r <= clk_ext;
         if (trig_wr) begin
            running_r <= 1'b1;
            cycle_cnt_r <= 4'h0;
            clk_int_r <= 1'b1;
         end else begin
            if (lead | trail) begin
               clk_int_r <= ~clk_int_r;
            end
            if (trail) begin
               cycle_cnt_r <= cycle_cnt_r + 4'h1;
            end
            if (last_trail) begin
               running_r <= 1'b0;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Shift register and serial output
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         transfer_data_byte_r <= 8'h00;
         serial_out_pin_r <= 1'b1;
      end else if (ce_i) begin
         if (lead) begin
            // Output moves on the leading edge for both polarities
            serial_out_pin_r <= bit_order_bit_r ? transfer_data_byte_r[7] :
                      transfer_data_byte_r[0];
         end
         if (sample_edge) begin
            if (bit_order_bit_r) begin
               transfer_data_byte_r <= {transfer_data_byte_r[6:0],
                                        serial_in_pin_i};
            end else begin
               transfer_data_byte_r <= {serial_in_pin_i,
                                        transfer_data_byte_r[7:1]};
            end
         end else begin
            if (wr_dlo) begin
               transfer_data_byte_r[3:0] <= wdata_r[3:0];
            end
            if (wr_dhi) begin
               transfer_data_byte_r[7:4] <= wdata_r[3:0];
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Completion flag
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         transfer_done_flag_r <= 1'b0;
      end else if (ce_i) begin
         // A completion in the same cycle as a clear keeps the flag
         if (last_trail) begin
            transfer_done_flag_r <= 1'b1;
         end else if (wr_flag & wdata_r[SSSP_FLAG_DONE]) begin
            transfer_done_flag_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Ready handshake
   // -----------------------------------------------------------------
   logic dhi_touch;
   assign dhi_touch = wr_dhi | (rd_fire & (rd_idx == SSSP_IDX_DHI));

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         ready_r <= 1'b0;
      end else if (ce_i) begin
         if (trig_wr & ~master) begin
            ready_r <= 1'b1;
         end else if (lead | dhi_touch | master) begin
            ready_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Pin drivers
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         serial_out_pin_o <= 1'b1;
         serial_out_oe_o <= 1'b0;
         sclk_pin_o <= ~POS_POL;
         sclk_pin_oe_o <= 1'b0;
         slave_ready_out_o <= ~POS_POL;
         slave_ready_oe_o <= 1'b0;
         transfer_irq_o <= 1'b0;
      end else if (ce_i) begin
         serial_out_pin_o <= serial_out_pin_r;
         serial_out_oe_o <= port_function_enable_r;
         // Idle clock level is high on the pin for negative polarity
         sclk_pin_o <= clk_int_r ^ POS_POL;
         sclk_pin_oe_o <= port_function_enable_r & master;
         slave_ready_out_o <= ready_r ^ ~POS_POL;
         slave_ready_oe_o <= port_function_enable_r & ~master;
         transfer_irq_o <= transfer_done_flag_r & transfer_irq_mask_r;
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite write channel
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_idx_r <= 16'h0000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= SSSP_RESP_OKAY;
      end else if (ce_i) begin
         s_axi_awready_o <= ~aw_got_r & ~(s_axi_awvalid_i & s_axi_awready_o) &
                            ~s_axi_bvalid_o;
         s_axi_wready_o <= ~w_got_r & ~(s_axi_wvalid_i & s_axi_wready_o) &
                           ~s_axi_bvalid_o;
         if (s_axi_awvalid_i & s_axi_awready_o) begin
            aw_got_r <= 1'b1;
            aw_idx_r <= reg_index(s_axi_awaddr_i);
         end
         if (s_axi_wvalid_i & s_axi_wready_o) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? SSSP_RESP_OKAY : SSSP_RESP_SLVERR;
         end else if (s_axi_bvalid_o & s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite read channel
   // -----------------------------------------------------------------
   logic [31:0] rd_data;
   logic rd_hit;

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      case (rd_idx)
         SSSP_IDX_CTRL: begin
            rd_data[SSSP_CTRL_PFE] = port_function_enable_r;
            rd_data[SSSP_CTRL_TRG] = running_r;
         end
         SSSP_IDX_MODE: begin
            rd_data[SSSP_MODE_CS_HI:SSSP_MODE_CS_LO] = clock_mode_r;
            rd_data[SSSP_MODE_PHASE] = clock_phase_bit_r;
            rd_data[SSSP_MODE_ORDER] = bit_order_bit_r;
         end
         SSSP_IDX_DLO: rd_data[3:0] = transfer_data_byte_r[3:0];
         SSSP_IDX_DHI: rd_data[3:0] = transfer_data_byte_r[7:4];
         SSSP_IDX_MASK: rd_data[SSSP_MASK_DONE] = transfer_irq_mask_r;
         SSSP_IDX_FLAG: rd_data[SSSP_FLAG_DONE] = transfer_done_flag_r;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= SSSP_RESP_OKAY;
      end else if (ce_i) begin
         s_axi_arready_o <= ~s_axi_rvalid_o & ~rd_fire;
         if (rd_fire) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_data;
            s_axi_rresp_o <= rd_hit ? SSSP_RESP_OKAY : SSSP_RESP_SLVERR;
         end else if (s_axi_rvalid_o & s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// >>> tb/sssp_checker.sv
// Assertion checker bound to the serial shift port top
`timescale 1ns/1ps
`default_nettype none
module sssp_checker
   import sssp_pkg::*;
#(
   parameter bit POS_POL = 1'b0,
   parameter int ADDR_W = 18
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic serial_out_pin_o,
   input wire logic serial_out_oe_o,
   input wire logic sclk_pin_i,
   input wire logic sclk_pin_o,
   input wire logic sclk_pin_oe_o,
   input wire logic slave_ready_out_o,
   input wire logic slave_ready_oe_o,
   input wire logic transfer_irq_o
);
   logic [4:0] edg_r;
   logic pin_r;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // ----------------------------------------------------------------
   // Master clock edges since the last trigger write
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      pin_r <= sclk_pin_o;
      if (!nrst_i || (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
          && s_axi_awaddr_i[ADDR_W-1:2] == SSSP_IDX_CTRL && s_axi_wdata_i[1])) begin
         edg_r <= 5'h0;
      end else if (sclk_pin_oe_o && pin_r != sclk_pin_o && edg_r != 5'h1f) begin
         edg_r <= edg_r + 5'h1;
      end
   end
   chk_rst_state: assert property ($rose(nrst_i) |->
      !sclk_pin_oe_o && slave_ready_out_o != POS_POL && !transfer_irq_o)
      else $error("state after reset wrong");
   chk_oe_excl: assert property (!(sclk_pin_oe_o && slave_ready_oe_o) &&
      (!sclk_pin_oe_o || serial_out_oe_o)) else $error("pin enables clash");
   chk_clk_count: assert property (edg_r <= 5'h10)
      else $error("master clock ran past eight cycles");
   chk_clk_idle: assert property (edg_r == 5'h10 |-> sclk_pin_o != POS_POL)
      else $error("master clock not idle after frame");
   chk_serial_out_pin_lead: assert property (sclk_pin_oe_o && $changed(serial_out_pin_o) |->
      sclk_pin_o == POS_POL && $past(sclk_pin_o) != POS_POL)
      else $error("serial out moved off leading edge");
   chk_rdy_release: assert property (slave_ready_oe_o && slave_ready_out_o == POS_POL &&
      $changed(sclk_pin_i) && sclk_pin_i == POS_POL |-> ##[1:6] slave_ready_out_o != POS_POL)
      else $error("ready kept active after leading edge");
   chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
   chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
   chk_rerr_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o != SSSP_RESP_OKAY |->
      s_axi_rresp_o == SSSP_RESP_SLVERR && s_axi_rdata_o == 32'h0)
      else $error("bad read error response");
   cov_ready: cover property ($fell(slave_ready_out_o));
   cov_irq: cover property ($rose(transfer_irq_o));
   cov_frame: cover property (edg_r == 5'h10);
endmodule
bind sssp_top sssp_checker #(.POS_POL(POS_POL), .ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

// >>> tb/sssp_ext_dev.sv
// Far-side serial device: clocks as master or follows as slave
`timescale 1ns/1ps
`default_nettype none
module sssp_ext_dev #(
   parameter int HALF = sssp_pkg::SSSP_MIN_HALF_CYC + 1
) (
   input wire logic mclk_i,
   input wire logic arm_i,
   input wire logic gen_i,
   input wire logic ph_i,
   input wire logic [7:0] tx_i,
   input wire logic [3:0] ncyc_i,
   input wire logic sclk_i,
   input wire logic serial_out_pin_i,
   output logic sclk_o,
   output logic sin_o,
   output logic [7:0] rx_o,
   output logic busy_o
);
   logic prv;
   int n, e, h, g;
   initial begin
      sclk_o = 1'b1;
      sin_o = 1'b0;
      busy_o = 1'b0;
      prv = 1'b1;
      rx_o = 8'h0;
   end
   always @(posedge mclk_i) begin
      prv <= sclk_i;
      if (!busy_o) begin
         sclk_o <= 1'b1;
         if (arm_i) begin
            busy_o <= 1'b1;
            n <= 0;
            e <= 0;
            h <= 0;
            g <= 0;
            sin_o <= tx_i[0];
         end else begin
            // Released line keeps toggling so a stale bit is never read
            sin_o <= ~sin_o;
         end
      end else begin
         if (gen_i) begin
            h <= (h == HALF - 1) ? 0 : h + 1;
            if (h == HALF - 1 && g < 2 * ncyc_i) begin
               sclk_o <= ~sclk_o;
               g <= g + 1;
            end
         end
         if (prv && !sclk_i) begin
            if (!ph_i) sin_o <= tx_i[n % 8];
            n <= n + 1;
         end
         if (!prv && sclk_i) begin
            if (e < 8) rx_o[e] <= serial_out_pin_i;
            if (ph_i) sin_o <= tx_i[(e + 1) % 8];
            e <= e + 1;
            if (e + 1 == ncyc_i) busy_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the serial shift port
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sssp_pkg::*;
   logic mclk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, s_axi_awvalid_i = 1'b0;
   logic s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic s_axi_rready_i = 1'b0, low_speed_osc_i = 1'b0, timer1_underflow_i = 1'b0;
   logic [17:0] s_axi_awaddr_i = 18'h0, s_axi_araddr_i = 18'h0;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rdat;
   logic [3:0] s_axi_wstrb_i = 4'hf, pnc = 4'h8;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic serial_in_pin_i, sclk_pin_i, serial_out_pin_o, serial_out_oe_o, sclk_pin_o;
   logic sclk_pin_oe_o, slave_ready_out_o, slave_ready_oe_o, transfer_irq_o;
   logic parm = 1'b0, pgen = 1'b0, pph = 1'b0, pclk, pbusy;
   logic [7:0] ptx = 8'h0, prx;
   int cyc = 0, num_errors = 0, tests_run = 0;
   sssp_top dut_u (.*);
   sssp_ext_dev peer_u (.mclk_i(mclk_i), .arm_i(parm), .gen_i(pgen), .ph_i(pph),
      .tx_i(ptx), .ncyc_i(pnc), .sclk_i(sclk_pin_i), .serial_out_pin_i(serial_out_pin_o),
      .sclk_o(pclk), .sin_o(serial_in_pin_i), .rx_o(prx), .busy_o(pbusy));
   assign sclk_pin_i = sclk_pin_oe_o ? sclk_pin_o : pclk;
   always #4 mclk_i = ~mclk_i;
   // ----------------------------------------------------------------
   // Clock sources and timeout
   // ----------------------------------------------------------------
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc % 64 == 63) low_speed_osc_i <= ~low_speed_osc_i;
      timer1_underflow_i <= (cyc % 64 == 63);
      if (cyc > 60000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic cmp_rng(input int v, input int lo, input int hi);
      tests_run++;
      if (v < lo || v > hi) begin
         num_errors++;
         $display("BAD %0t span %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask
   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
   endfunction
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      s_axi_awaddr_i <= {a, 2'h0};
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o && !s_axi_bready_i) s_axi_bready_i <= 1'b1;
      end while (!(s_axi_bvalid_o && s_axi_bready_i));
      resp = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [15:0] a);
      s_axi_araddr_i <= {a, 2'h0};
      s_axi_arvalid_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o && !s_axi_rready_i) s_axi_rready_i <= 1'b1;
      end while (!(s_axi_rvalid_o && s_axi_rready_i));
      rdat = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   // One frame; md is order, phase and clock mode, h the expected half period
   task automatic xfer(input logic [3:0] md, input logic [7:0] d, input logic [7:0] p,
                       input logic [3:0] nc, input int h, input logic m);
      int t0;
      logic [7:0] ex;
      ex = md[3] ? rev(p) : p;
      wr(SSSP_IDX_MODE, {28'h0, md});
      cmp(sclk_pin_oe_o, md[1:0] != 2'h0);
      wr(SSSP_IDX_MASK, {31'h0, m});
      wr(SSSP_IDX_DLO, {28'h0, d[3:0]});
      wr(SSSP_IDX_DHI, {28'h0, d[7:4]});
      ptx <= p;
      pph <= md[2];
      pnc <= nc;
      parm <= 1'b1;
      @(posedge mclk_i);
      parm <= 1'b0;
      wr(SSSP_IDX_CTRL, 32'h3);
      t0 = cyc;
      if (md[1:0] == 2'h0) begin
         cmp(slave_ready_out_o, 1'b0);
         pgen <= 1'b1;
      end
      rd(SSSP_IDX_CTRL);
      cmp(rdat, 32'h3);
      while (pbusy) @(posedge mclk_i);
      pgen <= 1'b0;
      if (md[1:0] != 2'h0) cmp_rng(cyc - t0, 15 * h, 18 * h);
      repeat (8) @(posedge mclk_i);
      rd(SSSP_IDX_CTRL);
      cmp(rdat, 32'h1);
      cmp(transfer_irq_o, m);
      rd(SSSP_IDX_FLAG);
      cmp(rdat, 32'h1);
      rd(SSSP_IDX_DLO);
      cmp(rdat, {28'h0, ex[3:0]});
      rd(SSSP_IDX_DHI);
      cmp(rdat, {28'h0, ex[7:4]});
      cmp(prx, md[3] ? rev(d) : d);
      cmp(slave_ready_out_o, 1'b1);
      wr(SSSP_IDX_FLAG, 32'h1);
      cmp(transfer_irq_o, 1'b0);
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      rd(SSSP_IDX_MODE);
      cmp(rdat, 32'h0);
      cmp(sclk_pin_oe_o, 1'b0);
      wr(SSSP_IDX_CTRL, 32'h1);
      cmp({slave_ready_oe_o, serial_out_oe_o}, 2'h3);
      wr(SSSP_IDX_CTRL, 32'h3);
      cmp(slave_ready_out_o, 1'b0);
      rd(SSSP_IDX_DHI);
      cmp(slave_ready_out_o, 1'b1);
      wr(SSSP_IDX_CTRL, 32'h3);
      wr(SSSP_IDX_DHI, 32'h0);
      cmp(slave_ready_out_o, 1'b1);
      wr(16'hff74, 32'h5);
      cmp(resp, SSSP_RESP_SLVERR);
      rd(16'hff74);
      cmp({resp, rdat}, {SSSP_RESP_SLVERR, 32'h0});
      // A mid-run reset cancels the slave transfer left armed above
      nrst_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      rd(SSSP_IDX_CTRL);
      cmp(rdat, 32'h0);
      cmp(slave_ready_out_o, 1'b1);
      wr(SSSP_IDX_CTRL, 32'h1);
      xfer(4'h3, 8'ha5, 8'h3c, 4'h8, 64, 1'b1);
      xfer(4'he, 8'h96, 8'h5a, 4'h8, 128, 1'b0);
      xfer(4'h9, 8'h81, 8'h7e, 4'h8, 64, 1'b1);
      xfer(4'h0, 8'hc3, 8'h18, 4'h8, 64, 1'b0);
      xfer(4'hc, 8'h4b, 8'he1, 4'h9, 64, 1'b1);
      test_done();
   end
endmodule
`default_nettype wire
